// file: verilog/down_timer_pwm_buzzer.sv
// Down-counting timer with prescaler, PWM output and tone generator on one pin.
// Assumes a single 20 MHz instruction clock; ext clock pin arrives asynchronously.
// Contract
// - Timer enable bit starts or stops the down-counter.
// - Clock select picks external pin clock or instruction clock.
// - Edge select picks falling or rising external edge.
// - Active-low prescaler enable divides source by 2 to 256.
// - Prescaler count is readable through its own register.
// - Timer write loads reload and counter; read returns count.
// - One-shot mode counts down once to zero and stops.
// - Continuous reload mode restarts from stored initial value.
// - Continuous wrap mode restarts from 0xFF.
// - Underflow sets sticky flag, cleared only by writing 0.
// - Interrupt asserts while flag, its enable and global enable set.
// - PWM enable plus PWM pin option drives and outputs the pin.
// - Polarity bit makes PWM active low, else active high.
// - Duty 0 never active; duty 0xFF active 255 input clocks.
// - Tone enable plus tone pin option drives and outputs the pin.
// - Tone source is prescaler output or timer output by bit 3.
// - Tone divides its source by 2 to 256 per select field.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "down_timer_defines.svh"

module down_timer_pwm_buzzer
  import down_timer_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       ext_clock_pin_in,
  output logic            shared_output_pin_out,
  output logic            shared_output_pin_oe_out,
  output logic            irq_out
);

  reg_req_t   req;
  run_state_t state_ff;
  logic [7:0] ctrl_one_ff;
  logic [7:0] ctrl_two_ff;
  logic [7:0] reload_ff;
  logic [7:0] count_ff;
  logic [7:0] duty_ff;
  logic [7:0] tone_ctrl_ff;
  logic [7:0] ps_count_ff;
  logic [7:0] tone_div_ff;
  logic       tone_ff;
  logic       pwm_ff;
  logic       pin_opt_ff;
  logic       flag_ff;
  logic       flag_en_ff;
  logic       global_en_ff;
  logic       ext_s1_ff;
  logic       ext_s2_ff;
  logic       ext_s3_ff;
  logic       src_tick;
  logic       ps_tick;
  logic       timer_tick;
  logic       underflow;
  logic       tone_tick;
  logic [7:0] ps_mask;
  logic [7:0] tone_mask;
  logic [7:0] nxt_count;
  pin_drive_t pin;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Mask of low bits for a divide by 2**(sel+1)
  function automatic logic [7:0] ratio_mask(input logic [2:0] sel);
    ratio_mask = 8'((9'h002 << sel) - 9'h001);
  endfunction

  // Control and data registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_one_ff  <= `RST_CTRL_ONE;
      ctrl_two_ff  <= `RST_CTRL_TWO;
      reload_ff    <= `RST_INITIAL;
      duty_ff      <= `RST_DUTY;
      tone_ctrl_ff <= `RST_TONE_CTRL;
      flag_en_ff   <= 1'b0;
      global_en_ff <= 1'b0;
      pin_opt_ff   <= `PIN_OPT_PWM;
    end else if (req.wr) begin
      if (req.addr == `ADDR_CTRL_ONE) begin
        ctrl_one_ff <= req.wdata;
      end else if (req.addr == `ADDR_CTRL_TWO) begin
        ctrl_two_ff <= req.wdata;
      end else if (req.addr == `ADDR_INITIAL) begin
        reload_ff <= req.wdata;
      end else if (req.addr == `ADDR_DUTY) begin
        duty_ff <= req.wdata;
      end else if (req.addr == `ADDR_TONE_CTRL) begin
        tone_ctrl_ff <= req.wdata;
      end else if (req.addr == `ADDR_IRQ_ENABLE) begin
        flag_en_ff <= req.wdata[`BIT_UNDERFLOW];
      end else if (req.addr == `ADDR_GLOBAL_IRQ) begin
        global_en_ff <= req.wdata[0];
      end else if (req.addr == `ADDR_PIN_OPTION) begin
        pin_opt_ff <= req.wdata[0];
      end
    end
  end

  // Two-stage synchroniser then edge detect on the third stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= ext_clock_pin_in;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // Source selection: instruction clock ticks every cycle
  always_comb begin
    if (ctrl_two_ff[`BIT_CLK_SEL]) begin
      src_tick = ctrl_two_ff[`BIT_EDGE_SEL] ? (ext_s3_ff & ~ext_s2_ff)
                                            : (~ext_s3_ff & ext_s2_ff);
    end else begin
      src_tick = 1'b1;
    end
  end

  // Prescaler; free-runs on the source so the tone can use it with timer stopped
  assign ps_mask = ratio_mask(ctrl_two_ff[2:0]);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ps_count_ff <= 8'h00;
    end else if (src_tick) begin
      ps_count_ff <= (ps_count_ff & ps_mask) == ps_mask ? 8'h00 : ps_count_ff + 8'h01;
    end
  end
  assign ps_tick    = src_tick && ((ps_count_ff & ps_mask) == ps_mask);
  assign timer_tick = ctrl_two_ff[`BIT_PS_EN_N] ? src_tick : ps_tick;

  // Underflow is the decrement out of 0x00's predecessor state
  assign underflow = (state_ff == ST_RUNNING) && timer_tick && count_ff == 8'h01;

  // Next counter value after a tick
  always_comb begin
    if (count_ff == 8'h01 && !ctrl_one_ff[`BIT_ONE_SHOT]) begin
      nxt_count = ctrl_one_ff[`BIT_RELOAD] ? reload_ff : `WRAP_VALUE;
    end else begin
      nxt_count = count_ff - 8'h01;
    end
  end

  // Counter and run state; a write restarts from the new initial value
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_ff <= `RST_INITIAL;
      state_ff <= ST_STOPPED;
    end else if (req.wr && req.addr == `ADDR_INITIAL) begin
      count_ff <= req.wdata;
      state_ff <= ctrl_one_ff[`BIT_TIMER_EN] ? ST_RUNNING : ST_STOPPED;
    end else if (!ctrl_one_ff[`BIT_TIMER_EN]) begin
      state_ff <= ST_STOPPED;
    end else begin
      case (state_ff)
        ST_STOPPED: begin
          state_ff <= ST_RUNNING;
        end
        ST_RUNNING: begin
          if (timer_tick) begin
            count_ff <= nxt_count;
            if (underflow && ctrl_one_ff[`BIT_ONE_SHOT]) begin
              state_ff <= ST_DONE;
            end
          end
        end
        default: begin
          state_ff <= ST_DONE;
        end
      endcase
    end
  end

  // Sticky flag; hardware set wins over a firmware clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag_ff <= 1'b0;
    end else if (underflow) begin
      flag_ff <= 1'b1;
    end else if (req.wr && req.addr == `ADDR_IRQ_FLAG && !req.wdata[`BIT_UNDERFLOW]) begin
      flag_ff <= 1'b0;
    end
  end
  assign irq_out = flag_ff & flag_en_ff & global_en_ff;

  // PWM: active while count is at or below duty; duty 0 never matches
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= (duty_ff != 8'h00) && (count_ff <= duty_ff);
    end
  end

  // Tone divider; ratio 2**(sel[2:0]+1), toggling halves each period
  assign tone_mask = ratio_mask(tone_ctrl_ff[2:0]) >> 1;
  assign tone_tick = tone_ctrl_ff[`BIT_TONE_SRC] ? underflow : ps_tick;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tone_div_ff <= 8'h00;
      tone_ff     <= 1'b0;
    end else if (!tone_ctrl_ff[`BIT_TONE_EN]) begin
      tone_div_ff <= 8'h00;
      tone_ff     <= 1'b0;
    end else if (tone_tick) begin
      if ((tone_div_ff & tone_mask) == tone_mask) begin
        tone_div_ff <= 8'h00;
        tone_ff     <= ~tone_ff;
      end else begin
        tone_div_ff <= tone_div_ff + 8'h01;
      end
    end
  end

  // Shared pin mux; polarity applied to PWM only
  always_comb begin
    pin = '{level: 1'b0, oe: 1'b0};
    if (pin_opt_ff == `PIN_OPT_PWM && ctrl_one_ff[`BIT_PWM_EN]) begin
      pin = '{level: pwm_ff ^ ctrl_one_ff[`BIT_PWM_LOW], oe: 1'b1};
    end else if (pin_opt_ff == `PIN_OPT_TONE && tone_ctrl_ff[`BIT_TONE_EN]) begin
      pin = '{level: tone_ff, oe: 1'b1};
    end
  end
  assign shared_output_pin_out    = pin.level;
  assign shared_output_pin_oe_out = pin.oe;

  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == `ADDR_CTRL_ONE) begin
        rdata_out <= ctrl_one_ff;
      end else if (req.addr == `ADDR_CTRL_TWO) begin
        rdata_out <= ctrl_two_ff;
      end else if (req.addr == `ADDR_INITIAL) begin
        rdata_out <= count_ff;
      end else if (req.addr == `ADDR_DUTY) begin
        rdata_out <= duty_ff;
      end else if (req.addr == `ADDR_TONE_CTRL) begin
        rdata_out <= tone_ctrl_ff;
      end else if (req.addr == `ADDR_PRESCALE) begin
        rdata_out <= ps_count_ff & ps_mask;
      end else if (req.addr == `ADDR_IRQ_FLAG) begin
        rdata_out <= 8'({flag_ff, 3'b000});
      end else if (req.addr == `ADDR_IRQ_ENABLE) begin
        rdata_out <= 8'({flag_en_ff, 3'b000});
      end else if (req.addr == `ADDR_GLOBAL_IRQ) begin
        rdata_out <= {7'h00, global_en_ff};
      end else if (req.addr == `ADDR_PIN_OPTION) begin
        rdata_out <= {7'h00, pin_opt_ff};
      end else begin
        rdata_out <= 8'h00;
      end
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Checks
  sequence s_last_tick;
    state_ff == ST_RUNNING && timer_tick && count_ff == 8'h01;
  endsequence

  a_timer_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_one_ff[0] && !(req.wr && req.addr == `ADDR_INITIAL) |=> $stable(count_ff))
    else $error("count moved while disabled");
  a_int_clock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_two_ff[5] && ctrl_two_ff[3] |-> timer_tick)
    else $error("instruction clock tick missing");
  a_edge_pick: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_two_ff[5] && ctrl_two_ff[3] && timer_tick |-> ext_s2_ff == !ctrl_two_ff[4])
    else $error("wrong external edge");
  a_write_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    req.wr && req.addr == `ADDR_INITIAL |=> count_ff == $past(req.wdata)
      && reload_ff == $past(req.wdata))
    else $error("timer write not loaded");
  a_one_shot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_last_tick ##0 (ctrl_one_ff[0] && ctrl_one_ff[2] && !req.wr) |=> count_ff == 8'h00
      && state_ff == ST_DONE)
    else $error("one-shot did not stop at zero");
  a_reload_next: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_last_tick ##0 (ctrl_one_ff[0] && !ctrl_one_ff[2] && ctrl_one_ff[1] && !req.wr)
      |=> count_ff == $past(reload_ff))
    else $error("reload value not restored");
  a_wrap_next: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_last_tick ##0 (ctrl_one_ff[0] && !ctrl_one_ff[2] && !ctrl_one_ff[1] && !req.wr)
      |=> count_ff == 8'hff)
    else $error("wrap not to 0xff");
  a_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    underflow |=> flag_ff)
    else $error("underflow flag not set");
  a_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_out == (flag_ff && flag_en_ff && global_en_ff))
    else $error("irq gating wrong");
  a_duty_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    duty_ff == 8'h00 && $past(duty_ff) == 8'h00 |-> !pwm_ff)
    else $error("pwm active with zero duty");

endmodule

// file: verilog/down_timer_defines.svh
// Offsets, field positions and reset values of the down-timer, PWM and tone block.
// Assumes inclusion by its bare name from the design module.
`ifndef DOWN_TIMER_DEFINES_SVH
`define DOWN_TIMER_DEFINES_SVH

// Register offsets on the plain register port
`define ADDR_CTRL_ONE   4'h0
`define ADDR_CTRL_TWO   4'h1
`define ADDR_INITIAL    4'h2
`define ADDR_DUTY       4'h3
`define ADDR_TONE_CTRL  4'h4
`define ADDR_PRESCALE   4'h5
`define ADDR_IRQ_FLAG   4'h6
`define ADDR_IRQ_ENABLE 4'h7
`define ADDR_GLOBAL_IRQ 4'h8
`define ADDR_PIN_OPTION 4'h9

// Control register one fields
`define BIT_TIMER_EN    0
`define BIT_RELOAD      1
`define BIT_ONE_SHOT    2
`define BIT_PWM_LOW     6
`define BIT_PWM_EN      7
// Control register two fields
`define BIT_PS_EN_N     3
`define BIT_EDGE_SEL    4
`define BIT_CLK_SEL     5
// Tone control fields
`define BIT_TONE_EN     7
`define BIT_TONE_SRC    3
// Interrupt flag and enable position
`define BIT_UNDERFLOW   3

// Reset values
`define RST_CTRL_ONE    8'h00
`define RST_CTRL_TWO    8'h08
`define RST_INITIAL     8'hff
`define RST_DUTY        8'h00
`define RST_TONE_CTRL   8'h00
`define RST_IRQ         8'h00

// Counter restart value after underflow without reload
`define WRAP_VALUE      8'hff
`define UNDER_VALUE     8'h00

// Pin option encoding
`define PIN_OPT_PWM     1'b0
`define PIN_OPT_TONE    1'b1

`endif

// file: verilog/down_timer_pkg.sv
// Types shared by the down-timer block.
// Assumes the defines header sits beside it.
package down_timer_pkg;
  // One register-port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Drive state of the shared pin
  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_t;

  // Counter run state
  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_RUNNING = 2'b01,
    ST_DONE    = 2'b10
  } run_state_t;
endpackage

// file: test/ext_clock_source.sv
// Far-side model: square wave on the external clock pin, and a pulled-up pin load.
// Assumes the bench clock; the wave stands still while run_in is low.
`timescale 1ns/100ps

module ext_clock_source #(
  parameter int HALF = 4
) (
  input  wire logic       clk_in,
  input  wire logic       run_in,
  input  wire logic       pin_in,
  input  wire logic       pin_oe_in,
  output logic            ext_pin_out,
  output logic            wire_level_out,
  output logic      [7:0] rises_out,
  output logic      [7:0] falls_out
);
  int phase = 0;

  // Undriven pin floats to the pull-up, never to the last driven level
  assign wire_level_out = pin_oe_in ? pin_in : 1'b1;

  initial begin
    ext_pin_out = 1'b0;
    rises_out = 8'h00;
    falls_out = 8'h00;
  end

  // Edges only inside a run window, so no stray counts between tests
  always @(posedge clk_in) begin
    if (run_in) begin
      phase <= (phase == HALF - 1) ? 0 : phase + 1;
      if (phase == HALF - 1) begin
        ext_pin_out <= ~ext_pin_out;
        if (ext_pin_out) falls_out <= falls_out + 8'h01;
        else rises_out <= rises_out + 8'h01;
      end
    end
  end
endmodule

// file: test/down_timer_pwm_buzzer_test.sv
// Self-checking bench for the down-timer, PWM and tone block.
// Assumes the plain register port and the external clock model beside it.
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module down_timer_pwm_buzzer_test;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       run = 1'b0;
  logic [7:0] rdata_out, rises, falls, a, b, r0;
  logic       pin, oe, irq_out, ext_pin, level;
  int         fail_count = 0, total_checks = 0, cyc = 0, hi, tr, oe_lo;

  down_timer_pwm_buzzer down_timer_pwm_buzzer_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_clock_pin_in(ext_pin), .shared_output_pin_out(pin),
    .shared_output_pin_oe_out(oe), .irq_out(irq_out));
  ext_clock_source ext_clock_source_inst (.clk_in(clk_in), .run_in(run), .pin_in(pin),
    .pin_oe_in(oe), .ext_pin_out(ext_pin), .wire_level_out(level),
    .rises_out(rises), .falls_out(falls));

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic wr(input logic [3:0] a_in, input logic [7:0] d_in);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a_in;
    wdata_in <= d_in;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a_in, output logic [7:0] d_out);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a_in;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d_out = rdata_out;
  endtask

  // Counts high cycles, transitions and undriven cycles of the pin over n intervals
  task automatic samp(input int n);
    logic last;
    @(posedge clk_in);
    #1 last = level;
    hi = 0;
    tr = 0;
    oe_lo = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1 hi += int'(level);
      tr += int'(level != last);
      oe_lo += int'(oe !== 1'b1);
      last = level;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(4'h1, a); `CHK(a, 8'h08)
    rd(4'h2, a); `CHK(a, 8'hff)
    rd(4'hf, a); `CHK(a, 8'h00)
    `CHK(oe, 1'b0)
    // Prescaler ratios 1:2, 1:4, 1:8, then bypassed, over exactly 40 cycles
    for (int s = 0; s < 4; s++) begin
      wr(4'h1, (s == 3) ? 8'h08 : 8'(s));
      wr(4'h0, 8'h00);
      wr(4'h2, 8'hff);
      wr(4'h0, 8'h01);
      rd(4'h2, a);
      repeat (38) @(posedge clk_in);
      rd(4'h2, b);
      `CHK(a - b, (s == 3) ? 8'h28 : 8'(8'h28 >> (s + 1)))
    end
    wr(4'h0, 8'h00);
    rd(4'h2, a);
    repeat (5) @(posedge clk_in);
    rd(4'h2, b); `CHK(b, a)
    wr(4'h1, 8'h07);
    rd(4'h5, a);
    repeat (3) @(posedge clk_in);
    rd(4'h5, b); `CHK(b - a, 8'h05)
    // External pin, rising then falling edges, no prescaler
    for (int e = 0; e < 2; e++) begin
      wr(4'h1, e ? 8'h38 : 8'h28);
      wr(4'h2, 8'hff);
      wr(4'h0, 8'h01);
      rd(4'h2, a);
      r0 = e ? falls : rises;
      run <= 1'b1;
      repeat (80) @(posedge clk_in);
      run <= 1'b0;
      repeat (8) @(posedge clk_in);
      rd(4'h2, b);
      `CHK(a - b, (e ? falls : rises) - r0)
      wr(4'h0, 8'h00);
    end
    // One-shot from 5, then the sticky flag and its interrupt gating
    wr(4'h1, 8'h08);
    wr(4'h2, 8'h05); rd(4'h2, a); `CHK(a, 8'h05)
    wr(4'h0, 8'h05);
    repeat (20) @(posedge clk_in);
    rd(4'h2, a); `CHK(a, 8'h00)
    rd(4'h6, a); `CHK(a, 8'h08)
    `CHK(irq_out, 1'b0)
    wr(4'h7, 8'h08);
    wr(4'h8, 8'h01);
    #1 `CHK(irq_out, 1'b1)
    wr(4'h7, 8'h00);
    #1 `CHK(irq_out, 1'b0)
    wr(4'h7, 8'h08);
    wr(4'h6, 8'h00);
    #1 `CHK(irq_out, 1'b0)
    rd(4'h6, a); `CHK(a, 8'h00)
    // Continuous wrap from 3 continues from the top, reload stays within 1..3
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h03);
    wr(4'h0, 8'h01);
    repeat (10) @(posedge clk_in);
    rd(4'h2, a); `CHK(a, 8'hf8)
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h03);
    wr(4'h0, 8'h03);
    repeat (10) @(posedge clk_in);
    rd(4'h2, a); `CHK(a, 8'h02)
    rd(4'h6, a); `CHK(a, 8'h08)
    // PWM on a frame of 4: duty 0, duty 1 active high, duty 1 active low
    wr(4'h0, 8'h00);
    wr(4'h9, 8'h00);
    wr(4'h2, 8'h04);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h83);
    samp(40); `CHK(hi, 0)
    `CHK(oe_lo, 0)
    wr(4'h3, 8'h01);
    repeat (8) @(posedge clk_in);
    samp(40); `CHK(hi, 10)
    wr(4'h0, 8'hc3);
    repeat (8) @(posedge clk_in);
    samp(40); `CHK(hi, 30)
    // Tone from timer underflow every 4 cycles, ratios 1:2 and 1:4
    wr(4'h0, 8'h03);
    wr(4'h9, 8'h01);
    for (int t = 0; t < 2; t++) begin
      wr(4'h4, 8'h88 + 8'(t));
      repeat (20) @(posedge clk_in);
      samp(48); `CHK(tr, t ? 6 : 12)
      `CHK(oe_lo, 0)
    end
    // Tone from the prescaler output at 1:2, ratio 1:2: a toggle every two cycles
    wr(4'h1, 8'h00);
    wr(4'h4, 8'h80);
    repeat (20) @(posedge clk_in);
    samp(48); `CHK(tr, 24)
    wr(4'h4, 8'h08);
    #1 `CHK(oe, 1'b0)
    final_report();
  end
endmodule
